// ==== core/pcfg_pkg.sv ====
// package of command codes, field layouts and reset values for the fault group register bank
package pcfg_pkg;
    // ****************************************************************
    // command codes
    // ****************************************************************
    localparam logic [7:0] PCFG_CMD_PHASE0_CURRENT = 8'hA1;
    localparam logic [7:0] PCFG_CMD_PHASE1_CURRENT = 8'hA2;
    localparam logic [7:0] PCFG_CMD_LISTEN_VECTOR = 8'hA8;
    localparam logic [7:0] PCFG_CMD_DEVICE_IDENTITY = 8'hAD;
    // ****************************************************************
    // data lengths in bytes
    // ****************************************************************
    localparam logic [2:0] PCFG_LEN_CURRENT = 3'h2;
    localparam logic [2:0] PCFG_LEN_BLOCK = 3'h4;
    // ****************************************************************
    // linear current word layout
    // ****************************************************************
    localparam int PCFG_EXP_MSB = 15;
    localparam int PCFG_EXP_LSB = 11;
    localparam int PCFG_MANT_MSB = 10;
    localparam int PCFG_MANT_LSB = 0;
    // ****************************************************************
    // reset values and widths
    // ****************************************************************
    localparam logic [31:0] PCFG_LISTEN_RESET = 32'h0000_0000;
    localparam int PCFG_RAILS = 32;
    localparam logic [7:0] PCFG_ID_RESERVED = 8'h00;
    // sequencing state of the device output
    typedef enum logic [1:0] {
        PCFG_RUN,
        PCFG_SPREAD_OFF,
        PCFG_SEQ_OFF,
        PCFG_RESTART
    } pcfg_state_t;
endpackage

// ==== core/pcfg_rail_match.sv ====
// per-rail filtering of peer fault events through the listen vector
`timescale 1ns/100ps
`default_nettype none
module pcfg_rail_match
    import pcfg_pkg::*;
(
    // listen set and peer faults
    input wire logic [31:0] i_listen,
    input wire logic [31:0] i_peer_fault,
    input wire logic [31:0] i_peer_event,
    // filtered results
    output logic o_any_event,
    output logic o_any_fault
);
    logic [31:0] ev_hit;
    logic [31:0] flt_hit;
    genvar g;
    generate
        for (g = 0; g < PCFG_RAILS; g = g + 1) begin : g_rail
            assign ev_hit[g] = i_listen[g] & i_peer_event[g];
            assign flt_hit[g] = i_listen[g] & i_peer_fault[g];
        end
    endgenerate
    assign o_any_event = |ev_hit;
    assign o_any_fault = |flt_hit;
endmodule // pcfg_rail_match
`default_nettype wire

// ==== core/pcfg_regs.sv ====
// command register bank for phase currents, fault listen vector and device identity
// Notes on behaviour
// - command A1h reads two bytes: phase 0 current, linear format
// - command A2h reads two bytes: phase 1 current, linear format
// - current readbacks are read only; writes never alter them
// - command A8h is a four-byte read-write 32-bit listen vector
// - byte 0 bit 0 is rail 0, up to byte 3 bit 7 rail 31
// - react to a peer fault event only when that rail's bit is set
// - a foreign current-share rail is down only when all its devices are
// - spread mode on: shut down at once on any group member fault; an event arriving in the PCFG_RESTART cycle is ignored
// - spread mode on: restart only after every group fault clears
// - spread mode off, sequencing on: group fault gives a sequenced shutdown
// - sequenced case: restart only after all group faults clear
// - spread and sequencing both off: ignore peer faults, stay enabled
// - listen vector resets to zero and may be write protected
// - command ADh reads four bytes: maker, id high, id low, reserved
`timescale 1ns/100ps
`default_nettype none
module pcfg_regs
    import pcfg_pkg::*;
#(
    // identity bytes: values arbitrary
    parameter logic [7:0] MAKER_CODE = 8'h5A,
    parameter logic [7:0] ID_HIGH = 8'h12,
    parameter logic [7:0] ID_LOW = 8'h34
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // command port from the serial bus engine
    input wire logic i_cmd_valid,
    input wire logic i_cmd_write,
    input wire logic [7:0] i_cmd_code,
    input wire logic [31:0] i_cmd_wdata,
    input wire logic i_write_protect,
    output logic o_rsp_valid,
    output logic o_rsp_ack,
    output logic [2:0] o_rsp_len,
    output logic [31:0] o_rsp_rdata,
    // measured currents, linear format
    input wire logic [15:0] i_phase0_current,
    input wire logic [15:0] i_phase1_current,
    // peer bus
    input wire logic [31:0] i_peer_fault,
    input wire logic [31:0] i_peer_event,
    input wire logic [3:0] i_share_present,
    input wire logic [3:0] i_share_down,
    // configuration
    input wire logic i_spread_en,
    input wire logic i_seq_en,
    input wire logic i_seq_step_done,
    // status
    output logic o_enable,
    output logic o_seq_shutdown,
    output logic o_restart,
    output logic o_rail_down,
    output logic [31:0] o_listen
);
    // ****************************************************************
    // registers
    // ****************************************************************
    logic [31:0] listen_r;
    logic rsp_valid_r;
    logic rsp_ack_r;
    logic [2:0] rsp_len_r;
    logic [31:0] rsp_rdata_r;
    logic any_event;
    logic any_fault;
    pcfg_state_t state_r;
    pcfg_state_t state_nxt;
    logic wr_listen;

    assign wr_listen = i_cmd_valid && i_cmd_write && !i_write_protect &&
                       (i_cmd_code == PCFG_CMD_LISTEN_VECTOR);

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            listen_r <= PCFG_LISTEN_RESET;
        end else if (wr_listen) begin
            // byte 0 lands in bits 7..0
            listen_r <= i_cmd_wdata;
        end
    end
    assign o_listen = listen_r;

    // ****************************************************************
    // command answers
    // ****************************************************************
    // answers to all four command codes
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            rsp_valid_r <= 1'b0;
            rsp_ack_r <= 1'b0;
            rsp_len_r <= 3'h0;
            rsp_rdata_r <= 32'h0000_0000;
        end else begin
            rsp_valid_r <= i_cmd_valid;
            rsp_ack_r <= 1'b0;
            rsp_len_r <= 3'h0;
            rsp_rdata_r <= 32'h0000_0000;
            if (i_cmd_valid) begin
                unique case (i_cmd_code)
                    // word passed through as a whole
                    PCFG_CMD_PHASE0_CURRENT: begin
                        rsp_ack_r <= !i_cmd_write;
                        rsp_len_r <= PCFG_LEN_CURRENT;
                        rsp_rdata_r <= {16'h0000, i_phase0_current};
                    end
                    PCFG_CMD_PHASE1_CURRENT: begin
                        rsp_ack_r <= !i_cmd_write;
                        rsp_len_r <= PCFG_LEN_CURRENT;
                        rsp_rdata_r <= {16'h0000, i_phase1_current};
                    end
                    PCFG_CMD_LISTEN_VECTOR: begin
                        rsp_ack_r <= !i_cmd_write || !i_write_protect;
                        rsp_len_r <= PCFG_LEN_BLOCK;
                        rsp_rdata_r <= listen_r;
                    end
                    PCFG_CMD_DEVICE_IDENTITY: begin
                        rsp_ack_r <= !i_cmd_write;
                        rsp_len_r <= PCFG_LEN_BLOCK;
                        rsp_rdata_r <= {MAKER_CODE, ID_HIGH, ID_LOW, PCFG_ID_RESERVED};
                    end
                    default: begin
                        rsp_ack_r <= 1'b0;
                    end
                endcase
            end
        end
    end
    assign o_rsp_valid = rsp_valid_r;
    assign o_rsp_ack = rsp_ack_r;
    assign o_rsp_len = rsp_len_r;
    assign o_rsp_rdata = rsp_rdata_r;

    // ****************************************************************
    // fault group reaction
    // ****************************************************************
    // own rail bit is the host's duty to keep clear
    // relies on host
    pcfg_rail_match u_match (
        .i_listen(listen_r),
        .i_peer_fault(i_peer_fault),
        .i_peer_event(i_peer_event),
        .o_any_event(any_event),
        .o_any_fault(any_fault)
    );

    pcfg_shared_rail u_share (
        .i_member_present(i_share_present),
        .i_member_down(i_share_down),
        .o_rail_down(o_rail_down)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PCFG_RUN: begin
                if (any_event && i_spread_en) begin
                    state_nxt = PCFG_SPREAD_OFF;
                end else if (any_event && i_seq_en) begin
                    state_nxt = PCFG_SEQ_OFF;
                end
            end
            PCFG_SPREAD_OFF: begin
                if (!any_fault) begin
                    state_nxt = PCFG_RESTART;
                end
            end
            PCFG_SEQ_OFF: begin
                if (!any_fault && i_seq_step_done) begin
                    state_nxt = PCFG_RESTART;
                end
            end
            PCFG_RESTART: begin
                state_nxt = PCFG_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= PCFG_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_enable = (state_r == PCFG_RUN) || (state_r == PCFG_RESTART);
    assign o_seq_shutdown = (state_r == PCFG_SEQ_OFF);
    assign o_restart = (state_r == PCFG_RESTART);

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_spread_event;
        any_event && i_spread_en && state_r == PCFG_RUN;
    endsequence

    AST_SPREAD_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_spread_event |=> !o_enable)
        else $error("spread event did not shut down");
    AST_SPREAD_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == PCFG_SPREAD_OFF && any_fault) |=> !o_restart)
        else $error("restart while group fault active");
    AST_SEQ_OFF: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == PCFG_RUN && any_event && !i_spread_en && i_seq_en) |=> o_seq_shutdown)
        else $error("no sequenced shutdown");
    AST_SEQ_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == PCFG_SEQ_OFF && any_fault) |=> o_seq_shutdown)
        else $error("sequenced restart too early");
    AST_IGNORE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == PCFG_RUN && !i_spread_en && !i_seq_en) |=> o_enable)
        else $error("device left enable with both modes off");
    AST_LISTEN_GATE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ((listen_r & i_peer_event) == 32'h0000_0000) |-> !any_event)
        else $error("unlisted rail triggered event");
    AST_PROTECT: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cmd_valid && i_write_protect) |=> $stable(listen_r))
        else $error("protected listen vector changed");
    AST_LISTEN_WR: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        wr_listen |=> listen_r == $past(i_cmd_wdata))
        else $error("listen vector write lost");
    AST_CUR0: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cmd_valid && !i_cmd_write && i_cmd_code == PCFG_CMD_PHASE0_CURRENT)
        |=> (o_rsp_len == PCFG_LEN_CURRENT && o_rsp_rdata[15:0] == $past(i_phase0_current)))
        else $error("phase 0 readback wrong");
    AST_CUR1: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cmd_valid && !i_cmd_write && i_cmd_code == PCFG_CMD_PHASE1_CURRENT)
        |=> (o_rsp_len == PCFG_LEN_CURRENT && o_rsp_rdata[15:0] == $past(i_phase1_current)))
        else $error("phase 1 readback wrong");
    AST_RO_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cmd_valid && i_cmd_write && i_cmd_code == PCFG_CMD_PHASE0_CURRENT)
        |=> (!o_rsp_ack && $stable(listen_r)))
        else $error("write to readback accepted");
    AST_IDENT: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cmd_valid && !i_cmd_write && i_cmd_code == PCFG_CMD_DEVICE_IDENTITY)
        |=> o_rsp_rdata[7:0] == PCFG_ID_RESERVED && o_rsp_len == PCFG_LEN_BLOCK)
        else $error("identity reserved byte wrong");

    // ****************************************************************
    // command port and reaction steps
    // ****************************************************************
    sequence s_rd_phase0;
        i_cmd_valid && !i_cmd_write && i_cmd_code == PCFG_CMD_PHASE0_CURRENT;
    endsequence
    sequence s_refused_wr;
        i_cmd_valid && i_cmd_write && (i_cmd_code == PCFG_CMD_PHASE0_CURRENT ||
            i_cmd_code == PCFG_CMD_PHASE1_CURRENT || i_cmd_code == PCFG_CMD_DEVICE_IDENTITY);
    endsequence
    sequence s_unknown_cmd;
        i_cmd_valid && i_cmd_code != PCFG_CMD_PHASE0_CURRENT &&
            i_cmd_code != PCFG_CMD_PHASE1_CURRENT && i_cmd_code != PCFG_CMD_LISTEN_VECTOR &&
            i_cmd_code != PCFG_CMD_DEVICE_IDENTITY;
    endsequence
    sequence s_spread_clear;
        state_r == PCFG_SPREAD_OFF && !any_fault;
    endsequence
    sequence s_seq_clear;
        state_r == PCFG_SEQ_OFF && !any_fault && i_seq_step_done;
    endsequence
    // restart pulse stands one cycle, output stays on after it
    sequence s_restart_run;
        (o_restart && o_enable) ##1 (!o_restart && o_enable);
    endsequence

    AST_RSP_PULSE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        i_cmd_valid |=> o_rsp_valid)
        else $error("command answer missing");
    AST_RSP_IDLE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        !i_cmd_valid |=> (!o_rsp_valid && !o_rsp_ack))
        else $error("answer without command");
    AST_LINEAR: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_rd_phase0 |=>
            (o_rsp_rdata[PCFG_EXP_MSB:PCFG_EXP_LSB] ==
                $past(i_phase0_current[PCFG_EXP_MSB:PCFG_EXP_LSB]) &&
            o_rsp_rdata[PCFG_MANT_MSB:PCFG_MANT_LSB] ==
                $past(i_phase0_current[PCFG_MANT_MSB:PCFG_MANT_LSB]) &&
            o_rsp_rdata[31:16] == 16'h0000))
        else $error("linear word fields moved");
    AST_RO_REFUSE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_refused_wr |=> (!o_rsp_ack && $stable(listen_r)))
        else $error("write to read only command accepted");
    AST_UNKNOWN: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_unknown_cmd |=> (!o_rsp_ack && o_rsp_len == 3'h0 &&
            o_rsp_rdata == 32'h0000_0000 && $stable(listen_r)))
        else $error("unknown command answered");
    AST_PROTECT_ACK: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_cmd_valid && i_cmd_write && i_write_protect &&
            i_cmd_code == PCFG_CMD_LISTEN_VECTOR) |=> !o_rsp_ack)
        else $error("protected write acknowledged");
    AST_SPREAD_PRIO: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_spread_event |=> !o_seq_shutdown)
        else $error("sequenced shutdown while spreading");
    AST_SPREAD_RESTART: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_spread_clear |=> s_restart_run)
        else $error("no restart after group cleared");
    AST_SEQ_RESTART: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        s_seq_clear |=> s_restart_run)
        else $error("no restart after sequenced clear");
    AST_SEQ_STEP: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == PCFG_SEQ_OFF && !i_seq_step_done) |=> o_seq_shutdown)
        else $error("restart before sequence done");
    AST_RAIL_UP: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        ((i_share_down & i_share_present) != i_share_present) |-> !o_rail_down)
        else $error("share rail down with member up");
    AST_RAIL_NONE: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
        (i_share_present == 4'h0) |-> !o_rail_down)
        else $error("empty share rail reported down");
endmodule // pcfg_regs
`default_nettype wire

// ==== core/pcfg_shared_rail.sv ====
// current-share rail shutdown report: rail is down only when all members are down
`timescale 1ns/100ps
`default_nettype none
module pcfg_shared_rail (
    // member status
    input wire logic [3:0] i_member_present,
    input wire logic [3:0] i_member_down,
    // rail status
    output logic o_rail_down
);
    assign o_rail_down = (i_member_present != 4'h0) &&
                         ((i_member_down & i_member_present) == i_member_present);
endmodule // pcfg_shared_rail
`default_nettype wire

// ==== testbench/pcfg_peer_model.sv ====
// peer controller model: per-rail fault levels and spreading events
`timescale 1ns/100ps
`default_nettype none
module pcfg_peer_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // faults the bench asks the peers to hold
    input wire logic [31:0] i_fault_req,
    // peer bus view
    output logic [31:0] o_peer_fault,
    output logic [31:0] o_peer_event
);
    logic [31:0] fault_r;
    // a peer announces a fault once, when it first appears
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            fault_r <= 32'h0000_0000;
            o_peer_event <= 32'h0000_0000;
        end else begin
            fault_r <= i_fault_req;
            o_peer_event <= i_fault_req & ~fault_r;
        end
    end
    assign o_peer_fault = fault_r;
endmodule // pcfg_peer_model
`default_nettype wire

// ==== testbench/pcfg_regs_tb.sv ====
// self-checking bench for the fault group register bank
`timescale 1ns/100ps
`default_nettype none
module pcfg_regs_tb;
    import pcfg_pkg::*;
    // identity bytes: values arbitrary
    localparam logic [7:0] MK = 8'h6B;
    localparam logic [7:0] IDH = 8'h2C;
    localparam logic [7:0] IDL = 8'h71;
    logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_write = 1'b0, wp = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [31:0] cmd_wdata = 32'h0, fault_req = 32'h0, peer_fault, peer_event, listen, rdata;
    logic [15:0] ph0 = 16'hD3FF, ph1 = 16'h1A01;
    logic [3:0] sh_pres = 4'h0, sh_down = 4'h0;
    logic spread = 1'b0, seq = 1'b0, step = 1'b0;
    logic rsp_valid, ack, enable, seq_off, restart, rail_down, en_low, seq_hi;
    logic [2:0] len;
    int n_errors = 0, cmp_count = 0, n_rst;
    always #2.5 clk = ~clk;
    pcfg_peer_model peers (.i_clk_sys(clk), .i_rstn(rstn), .i_fault_req(fault_req),
        .o_peer_fault(peer_fault), .o_peer_event(peer_event));
    pcfg_regs #(.MAKER_CODE(MK), .ID_HIGH(IDH), .ID_LOW(IDL)) dut (.i_clk_sys(clk),
        .i_rstn(rstn), .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write), .i_cmd_code(cmd_code),
        .i_cmd_wdata(cmd_wdata), .i_write_protect(wp), .o_rsp_valid(rsp_valid), .o_rsp_ack(ack),
        .o_rsp_len(len), .o_rsp_rdata(rdata), .i_phase0_current(ph0), .i_phase1_current(ph1),
        .i_peer_fault(peer_fault), .i_peer_event(peer_event), .i_share_present(sh_pres),
        .i_share_down(sh_down), .i_spread_en(spread), .i_seq_en(seq), .i_seq_step_done(step),
        .o_enable(enable), .o_seq_shutdown(seq_off), .o_restart(restart),
        .o_rail_down(rail_down), .o_listen(listen));
    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // one command, answer judged in the cycle it stands
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [31:0] wd,
        input logic ex_ack, input logic [2:0] ex_len, input logic [31:0] ex_data, input bit cd);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = wd;
        @(posedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
        chk("ack", {31'h0, ex_ack}, {31'h0, ack});
        chk("len", {29'h0, ex_len}, {29'h0, len});
        if (cd) chk("rdata", ex_data, rdata);
    endtask
    task automatic watch(input int n);
        en_low = 1'b0;
        seq_hi = 1'b0;
        n_rst = 0;
        repeat (n) begin
            @(negedge clk);
            if (enable !== 1'b1) en_low = 1'b1;
            if (seq_off === 1'b1) seq_hi = 1'b1;
            if (restart === 1'b1) n_rst++;
        end
    endtask
    task automatic final_report;
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs;
        chk("listen reset", PCFG_LISTEN_RESET, listen);
        cmd(1'b0, PCFG_CMD_LISTEN_VECTOR, 32'h0, 1'b1, PCFG_LEN_BLOCK, 32'h0, 1);
        cmd(1'b1, PCFG_CMD_LISTEN_VECTOR, 32'hA5C3_0F81, 1'b1, PCFG_LEN_BLOCK,
            32'h0, 1);
        chk("listen", 32'hA5C3_0F81, listen);
        // a refused write still reports the block length
        wp = 1'b1;
        cmd(1'b1, PCFG_CMD_LISTEN_VECTOR, 32'hFFFF_FFFF, 1'b0, PCFG_LEN_BLOCK,
            32'hA5C3_0F81, 1);
        chk("protected listen", 32'hA5C3_0F81, listen);
        wp = 1'b0;
        cmd(1'b0, PCFG_CMD_LISTEN_VECTOR, 32'h0, 1'b1, PCFG_LEN_BLOCK,
            32'hA5C3_0F81, 1);
        cmd(1'b0, PCFG_CMD_DEVICE_IDENTITY, 32'h0, 1'b1, PCFG_LEN_BLOCK,
            {MK, IDH, IDL, PCFG_ID_RESERVED}, 1);
        cmd(1'b1, PCFG_CMD_DEVICE_IDENTITY, 32'h1, 1'b0, PCFG_LEN_BLOCK, 32'h0, 0);
        cmd(1'b0, 8'hA3, 32'h0, 1'b0, 3'h0, 32'h0, 1);
    endtask
    task automatic t_currents;
        cmd(1'b0, PCFG_CMD_PHASE0_CURRENT, 32'h0, 1'b1, PCFG_LEN_CURRENT,
            {16'h0, ph0}, 1);
        cmd(1'b1, PCFG_CMD_PHASE0_CURRENT, 32'h0, 1'b0, PCFG_LEN_CURRENT,
            32'h0, 0);
        // exponent 1Ah and mantissa 3FFh kept in their own fields
        cmd(1'b0, PCFG_CMD_PHASE0_CURRENT, 32'h0, 1'b1, PCFG_LEN_CURRENT,
            {16'h0, 5'h1A, 11'h3FF}, 1);
        cmd(1'b0, PCFG_CMD_PHASE1_CURRENT, 32'h0, 1'b1, PCFG_LEN_CURRENT,
            {16'h0, ph1}, 1);
        cmd(1'b1, PCFG_CMD_PHASE1_CURRENT, 32'hFFFF, 1'b0, PCFG_LEN_CURRENT,
            32'h0, 0);
        cmd(1'b0, PCFG_CMD_PHASE1_CURRENT, 32'h0, 1'b1, PCFG_LEN_CURRENT,
            {16'h0, ph1}, 1);
    endtask
    // own rail is 5 and stays out of the vector
    task automatic t_spread;
        cmd(1'b1, PCFG_CMD_LISTEN_VECTOR, 32'h8000_0001, 1'b1, PCFG_LEN_BLOCK,
            32'h0, 0);
        spread = 1'b1;
        fault_req = 32'h0000_0080;
        watch(4);
        chk("unlisted event", 32'h0, {31'h0, en_low});
        fault_req = 32'h8000_0080;
        watch(2);
        chk("enable rail 31", 32'h0, {31'h0, enable});
        fault_req = 32'h0000_0081;
        watch(4);
        chk("early restart", 32'h0, n_rst);
        fault_req = 32'h0000_0080;
        watch(4);
        chk("restart", 32'h1, n_rst);
        chk("enable back", 32'h1, {31'h0, enable});
        fault_req = 32'h0000_0001;
        watch(2);
        chk("enable rail 0", 32'h0, {31'h0, enable});
        fault_req = 32'h0;
        watch(4);
        spread = 1'b0;
    endtask
    task automatic t_seq;
        seq = 1'b1;
        fault_req = 32'h8000_0000;
        watch(2);
        chk("seq shutdown", 32'h1, {31'h0, seq_off});
        fault_req = 32'h0;
        watch(4);
        chk("restart before step", 32'h0, n_rst);
        step = 1'b1;
        watch(4);
        chk("seq restart", 32'h1, n_rst);
        step = 1'b0;
        seq = 1'b0;
        fault_req = 32'h0000_0001;
        watch(5);
        chk("ignored fault", 32'h0, {30'h0, en_low, seq_hi});
        fault_req = 32'h0;
        watch(2);
    endtask
    task automatic t_share;
        sh_pres = 4'h3;
        sh_down = 4'h1;
        watch(1);
        chk("rail down partial", 32'h0, {31'h0, rail_down});
        sh_down = 4'h3;
        watch(1);
        chk("rail down all", 32'h1, {31'h0, rail_down});
        sh_pres = 4'h0;
        watch(1);
        chk("rail down none", 32'h0, {31'h0, rail_down});
    endtask
    // mid-run reset clears the vector written by the spread scenario
    task automatic t_reset;
        rstn = 1'b0;
        watch(2);
        chk("listen in reset", PCFG_LISTEN_RESET, listen);
        rstn = 1'b1;
        watch(2);
        chk("listen after reset", PCFG_LISTEN_RESET, listen);
        chk("enable after reset", 32'h1, {31'h0, enable});
        cmd(1'b0, PCFG_CMD_LISTEN_VECTOR, 32'h0, 1'b1, PCFG_LEN_BLOCK, 32'h0, 1);
    endtask
    initial begin
        #20000;
        n_errors++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        chk("enable reset", 32'h1, {31'h0, enable});
        t_regs();
        t_currents();
        t_spread();
        t_seq();
        t_share();
        t_reset();
        final_report();
    end
endmodule // pcfg_regs_tb
`default_nettype wire
